// ==== verilog/sad_consts.vh ====
`ifndef SAD_CONSTS_VH
`define SAD_CONSTS_VH
// bank select: address bits 31:28, sixteen 256 MB banks
`define SAD_BANK_MSB      31
`define SAD_BANK_LSB      28
`define SAD_BANK_INT      4'h0
`define SAD_BANK_EXT_LO   4'h1
`define SAD_BANK_EXT_HI   4'h9
`define SAD_BANK_PERIPH   4'hf
// second level inside bank 0: 1 MB areas, bits 27:20
`define SAD_AREA_MSB      27
`define SAD_AREA_LSB      20
`define SAD_AREA_BOOT     8'h00
`define SAD_AREA_INSTR    8'h01
`define SAD_AREA_DATA     8'h02
`define SAD_AREA_AHB      8'h03
`define SAD_AREA_ROM      8'h04
`define SAD_AREA_SRAM16   8'h05
// 16 KB block offset inside an area
`define SAD_BLK_MSB       19
`define SAD_BLK_LSB       14
// size codes: 0 = none, 1 = 16 KB, 2 = 32 KB
`define SAD_SIZE_0K       2'h0
`define SAD_SIZE_16K      2'h1
`define SAD_SIZE_32K      2'h2
`define SAD_RAM_BLOCKS    5
// slave one-hot positions
`define SAD_SL_ROM        0
`define SAD_SL_SPLIT      1
`define SAD_SL_SRAM16     2
`define SAD_SL_EXT0       3
`define SAD_SL_EXT1       4
`define SAD_SL_APB        5
`define SAD_SL_ABORT      6
`define SAD_SL_W          7
// reset values
`define SAD_REMAP_RST     1'b0
`define SAD_SIZE_RST      2'h0
`endif

// ==== verilog/sad_master_decoder.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sad_consts.vh"
// one private decoder per master; purely combinational
module sad_master_decoder #(
  parameter IS_CPU = 0
) (
  input  wire [31:0] addr,
  input  wire        remap,
  input  wire        bootRom,
  input  wire [1:0]  instrSize,
  input  wire [1:0]  dataSize,
  output reg  [6:0]  slaveSel,
  output reg  [3:0]  extCs,
  output reg  [2:0]  ramBlock,
  output reg  [13:0] localAddr
);

  // physical block behind logical slot of the bus region; non-contiguous by design
  function [3:0] ahbBlock;  // {valid, block}
    input [5:0] slot;
    input [1:0] isz;
    input [1:0] dsz;
    reg   [4:0] taken;
    reg   [2:0] n;
    integer     b;
    begin
      taken = 5'h00;
      ahbBlock = 4'h0;
      n = 3'h0;
      if (isz != `SAD_SIZE_0K) taken[1] = 1'b1;
      if (isz == `SAD_SIZE_32K) taken[0] = 1'b1;
      if (dsz != `SAD_SIZE_0K) taken[3] = 1'b1;
      if (dsz == `SAD_SIZE_32K) taken[2] = 1'b1;
      // block 4 is never taken, so the bus region always keeps it
      for (b = 4; b >= 0; b = b - 1)
      begin
        if (!taken[b])
        begin
          if ({3'h0, n} == slot)
            ahbBlock = {1'b1, b[2:0]};
          n = n + 3'h1;
        end
      end
    end
  endfunction

  reg  [3:0] hit;
  wire [3:0] bank = addr[`SAD_BANK_MSB:`SAD_BANK_LSB];
  wire [7:0] area = addr[`SAD_AREA_MSB:`SAD_AREA_LSB];
  wire [5:0] slot = addr[`SAD_BLK_MSB:`SAD_BLK_LSB];

  always @*
  begin
    slaveSel = 7'h00;
    extCs = 4'h0;
    ramBlock = 3'h0;
    localAddr = addr[13:0];
    hit = 4'h0;
    if (bank == `SAD_BANK_INT)
    begin
      case (area)
        `SAD_AREA_BOOT:
          if (IS_CPU != 0 && remap)
          begin
            hit = ahbBlock(slot, instrSize, dataSize);
            slaveSel[`SAD_SL_SPLIT] = hit[3];
            ramBlock = hit[2:0];
            slaveSel[`SAD_SL_ABORT] = ~hit[3];
          end
          else if (bootRom)
            slaveSel[`SAD_SL_ROM] = 1'b1;
          else
          begin
            slaveSel[`SAD_SL_EXT0] = 1'b1;
            extCs = 4'h0;
          end
        `SAD_AREA_INSTR:
          if (slot == 6'h00 && instrSize != `SAD_SIZE_0K)
          begin
            slaveSel[`SAD_SL_SPLIT] = 1'b1;
            ramBlock = 3'h1;
          end
          else if (slot == 6'h01 && instrSize == `SAD_SIZE_32K)
          begin
            slaveSel[`SAD_SL_SPLIT] = 1'b1;
            ramBlock = 3'h0;
          end
          else
            slaveSel[`SAD_SL_ABORT] = 1'b1;
        `SAD_AREA_DATA:
          if (slot == 6'h00 && dataSize != `SAD_SIZE_0K)
          begin
            slaveSel[`SAD_SL_SPLIT] = 1'b1;
            ramBlock = 3'h3;
          end
          else if (slot == 6'h01 && dataSize == `SAD_SIZE_32K)
          begin
            slaveSel[`SAD_SL_SPLIT] = 1'b1;
            ramBlock = 3'h2;
          end
          else
            slaveSel[`SAD_SL_ABORT] = 1'b1;
        `SAD_AREA_AHB:
        begin
          hit = ahbBlock(slot, instrSize, dataSize);
          slaveSel[`SAD_SL_SPLIT] = hit[3];
          ramBlock = hit[2:0];
          slaveSel[`SAD_SL_ABORT] = ~hit[3];
        end
        `SAD_AREA_ROM:
          slaveSel[`SAD_SL_ROM] = 1'b1;
        `SAD_AREA_SRAM16:
          if (slot == 6'h00)
            slaveSel[`SAD_SL_SRAM16] = 1'b1;
          else
            slaveSel[`SAD_SL_ABORT] = 1'b1;
        default:
          slaveSel[`SAD_SL_ABORT] = 1'b1;
      endcase
    end
    else if (bank >= `SAD_BANK_EXT_LO && bank <= `SAD_BANK_EXT_HI)
    begin
      if (bank <= 4'h6)
      begin
        slaveSel[`SAD_SL_EXT0] = 1'b1;
        extCs = bank - 4'h1;
      end
      else
      begin
        slaveSel[`SAD_SL_EXT1] = 1'b1;
        extCs = bank - 4'h7;
      end
    end
    else if (bank == `SAD_BANK_PERIPH)
      slaveSel[`SAD_SL_APB] = 1'b1;
    else
      slaveSel[`SAD_SL_ABORT] = 1'b1;
  end

endmodule // sad_master_decoder
`default_nettype wire

// ==== verilog/sad_system_address_decoder.v ====
// Overview of operation
// - address bits 31:28 pick one of sixteen 256 MB banks
// - banks one to nine go to external chip selects
// - bank zero holds internal memories, decoded again in 1 MB areas
// - bank fifteen goes to the peripheral bridge
// - unassigned addresses answer with an error response
// - every master has its own decoder with a similar map
// - processor masters see boot ROM, external boot or SRAM at zero
// - remap clear: ROM if boot select high, else external cs zero; set: SRAM
// - instruction coupled region also visible at 0x0010_0000
// - data coupled region also visible at 0x0020_0000
// - bus region only on the system bus, at 0x0030_0000 from reset
// - after remap the bus region also appears at zero for processor masters
// - coupled regions sized 0, 16 or 32 KB each; rest is bus region
// - one 16 KB block always belongs to the bus region
// - after reset all 80 KB belong to the bus region
// - blocks are assigned non-contiguously; resizing moves contents
// - ROM, split SRAM and 16 KB SRAM answer in one cycle
// - split SRAM also serves coupled ports in one cycle
// - boot select is sampled three edges after reset release: high ROM, low external cs zero
// - 0x0 to 0x000f_ffff is reserved for the boot memory
`timescale 1ns/1ps
`default_nettype none
`include "sad_consts.vh"
module sad_system_address_decoder #(
  parameter MASTERS = 9,
  parameter CPU_D   = 7,
  parameter CPU_I   = 8
) (
  input  wire                   clk,
  input  wire                   arst_n,
  input  wire                   bootMemorySelect,
  input  wire                   remapSet,
  input  wire                   remapClear,
  input  wire                   sizeWrite,
  input  wire [1:0]             instrSizeIn,
  input  wire [1:0]             dataSizeIn,
  input  wire [MASTERS-1:0]     req,
  input  wire [MASTERS*32-1:0]  reqAddr,
  output reg  [MASTERS-1:0]     ack,
  output reg  [MASTERS-1:0]     err,
  output reg  [MASTERS*7-1:0]   slaveSel,
  output reg  [MASTERS*4-1:0]   extCs,
  output reg  [MASTERS*3-1:0]   ramBlock,
  output reg  [MASTERS*14-1:0]  localAddr,
  output reg                    remap,
  output reg                    bootRom,
  output reg  [1:0]             instrSize,
  output reg  [1:0]             dataSize,
  output reg  [4:0]             ahbBlocks
);

  // boot select comes from a pin: two flops before use
  reg        bootSelMeta;
  reg        bootSelSync;
  reg        strapDone;
  wire [MASTERS*7-1:0]  decSel;
  wire [MASTERS*4-1:0]  decCs;
  wire [MASTERS*3-1:0]  decBlk;
  wire [MASTERS*14-1:0] decLoc;

  function [1:0] legalSize;
    input [1:0] s;
    begin
      legalSize = (s == 2'h3) ? `SAD_SIZE_32K : s;
    end
  endfunction

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bootSelMeta <= 1'b0;
      bootSelSync <= 1'b0;
    end
    else
    begin
      bootSelMeta <= bootMemorySelect;
      bootSelSync <= bootSelMeta;
    end
  end

  // strap caught once, three edges after release when the synchroniser is settled
  reg [1:0] strapCnt;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strapCnt <= 2'h0;
      strapDone <= 1'b0;
      bootRom <= 1'b1;
    end
    else if (!strapDone)
    begin
      strapCnt <= strapCnt + 2'h1;
      if (strapCnt == 2'h2)
      begin
        bootRom <= bootSelSync;
        strapDone <= 1'b1;
      end
    end
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      remap <= `SAD_REMAP_RST;
      instrSize <= `SAD_SIZE_RST;
      dataSize <= `SAD_SIZE_RST;
      ahbBlocks <= 5'h1f;
    end
    else
    begin
      if (remapSet)
        remap <= 1'b1;
      else if (remapClear)
        remap <= 1'b0;
      if (sizeWrite)
      begin
        instrSize <= legalSize(instrSizeIn);
        dataSize <= legalSize(dataSizeIn);
      end
      // block 4 never leaves the bus region
      ahbBlocks <= {1'b1,
                    ~(dataSize != `SAD_SIZE_0K),
                    ~(dataSize == `SAD_SIZE_32K),
                    ~(instrSize != `SAD_SIZE_0K),
                    ~(instrSize == `SAD_SIZE_32K)};
    end
  end

  genvar m;
  generate
    for (m = 0; m < MASTERS; m = m + 1)
    begin : gMaster
      sad_master_decoder #(
        .IS_CPU ((m == CPU_D || m == CPU_I) ? 1 : 0)
      ) uDec (
        .addr      (reqAddr[m*32 +: 32]),
        .remap     (remap),
        .bootRom   (bootRom),
        .instrSize (instrSize),
        .dataSize  (dataSize),
        .slaveSel  (decSel[m*7 +: 7]),
        .extCs     (decCs[m*4 +: 4]),
        .ramBlock  (decBlk[m*3 +: 3]),
        .localAddr (decLoc[m*14 +: 14])
      );
    end
  endgenerate

  // registered answer: exactly one cycle after the request
  integer i;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack <= {MASTERS{1'b0}};
      err <= {MASTERS{1'b0}};
      slaveSel <= {(MASTERS*7){1'b0}};
      extCs <= {(MASTERS*4){1'b0}};
      ramBlock <= {(MASTERS*3){1'b0}};
      localAddr <= {(MASTERS*14){1'b0}};
    end
    else
    begin
      for (i = 0; i < MASTERS; i = i + 1)
      begin
        ack[i] <= req[i] & ~decSel[i*7 + `SAD_SL_ABORT];
        err[i] <= req[i] & decSel[i*7 + `SAD_SL_ABORT];
        slaveSel[i*7 +: 7] <= req[i] ? decSel[i*7 +: 7] : 7'h00;
        extCs[i*4 +: 4] <= decCs[i*4 +: 4];
        ramBlock[i*3 +: 3] <= decBlk[i*3 +: 3];
        localAddr[i*14 +: 14] <= decLoc[i*14 +: 14];
      end
    end
  end

endmodule // sad_system_address_decoder
`default_nettype wire

// ==== verif/sad_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module sad_chk #(
  parameter MASTERS = 9
) (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic                  remapSet,
  input wire logic                  sizeWrite,
  input wire logic [1:0]            instrSizeIn,
  input wire logic [MASTERS-1:0]    req,
  input wire logic [MASTERS*32-1:0] reqAddr,
  input wire logic [MASTERS-1:0]    ack,
  input wire logic [MASTERS-1:0]    err,
  input wire logic [MASTERS*7-1:0]  slaveSel,
  input wire logic [MASTERS*3-1:0]  ramBlock,
  input wire logic                  remap,
  input wire logic [1:0]            instrSize
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // master 0 is a plain bus master, master 7 the processor data master
  wire logic [3:0]  bk = reqAddr[31:28];
  wire logic [31:0] a7 = reqAddr[255:224];
  property p_ans; req[0] |=> ack[0] != err[0]; endproperty
  a_ans: assert property (p_ans)
    else $error("no single answer");
  property p_idle; !req[7] |=> !ack[7] && !err[7] && slaveSel[55:49] == 7'h0; endproperty
  a_idle: assert property (p_idle)
    else $error("answer without request");
  property p_ext; req[0] && bk inside {[1:9]} |=> ack[0] && (slaveSel[3] || slaveSel[4]);
  endproperty
  a_ext: assert property (p_ext)
    else $error("external bank misrouted");
  property p_per; req[7] && a7[31:28] == 4'hf |=> ack[7] && slaveSel[54]; endproperty
  a_per: assert property (p_per)
    else $error("peripheral bank misrouted");
  property p_abort; req[0] && bk inside {[10:14]} |=> err[0] && slaveSel[6]; endproperty
  a_abort: assert property (p_abort)
    else $error("unused bank not aborted");
  property p_remap; remapSet |=> remap; endproperty
  a_remap: assert property (p_remap)
    else $error("remap not set");
  // size code 3 is taken as 32 KB
  property p_size;
    sizeWrite |=> instrSize == (($past(instrSizeIn) == 2'h3) ? 2'h2 : $past(instrSizeIn));
  endproperty
  a_size: assert property (p_size)
    else $error("size not loaded");
  property p_base; req[7] && a7[31:14] == 18'h000c0 |=> slaveSel[50] && ramBlock[23:21] == 3'h4;
  endproperty
  a_base: assert property (p_base)
    else $error("bus region base block wrong");
  property p_zero;
    req[7] && a7[31:14] == 18'h0 && remap |=> slaveSel[50] && ramBlock[23:21] == 3'h4;
  endproperty
  a_zero: assert property (p_zero)
    else $error("remapped zero not sram");
endmodule // sad_chk
`default_nettype wire

// ==== verif/sad_master_bfm.sv ====
`timescale 1ns/1ps
`default_nettype none
module sad_master_bfm (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        go,
  input  wire logic [31:0] goAddr,
  output var  logic        req,
  output var  logic [31:0] addr
);
  // an idle master shows a changing address so a stale one is never decoded
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      req <= 1'b0;
      addr <= 32'hffff_ffff;
    end
    else
    begin
      req <= go;
      addr <= go ? goAddr : ~addr;
    end
endmodule // sad_master_bfm
`default_nettype wire

// ==== verif/sad_system_address_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sad_system_address_decoder_tb;
  localparam MASTERS = 9;
  logic clk = 1'b0, arst_n = 1'b0, bootMemorySelect = 1'b1;
  logic remapSet = 1'b0, remapClear = 1'b0, sizeWrite = 1'b0;
  logic [1:0]  instrSizeIn = 2'h0, dataSizeIn = 2'h0, go = 2'h0;
  logic [31:0] ga0 = 32'h0, ga7 = 32'h0, a0, a7;
  logic        r0, r7;
  logic [29:0] q[$];
  logic [29:0] got;
  int          bad_count = 0, checked = 0;
  wire logic [MASTERS-1:0]    req = {1'b0, r7, 6'h0, r0};
  wire logic [MASTERS*32-1:0] reqAddr = {32'h0, a7, 192'h0, a0};
  wire logic [MASTERS-1:0]    ack, err;
  wire logic [MASTERS*7-1:0]  slaveSel;
  wire logic [MASTERS*4-1:0]  extCs;
  wire logic [MASTERS*3-1:0]  ramBlock;
  wire logic [MASTERS*14-1:0] localAddr;
  wire logic                  remap, bootRom;
  wire logic [1:0]            instrSize, dataSize;
  wire logic [4:0]            ahbBlocks;
  always #5 clk = ~clk;
  sad_master_bfm m0 (.clk, .arst_n, .go(go[0]), .goAddr(ga0), .req(r0), .addr(a0));
  sad_master_bfm m7 (.clk, .arst_n, .go(go[1]), .goAddr(ga7), .req(r7), .addr(a7));
  sad_system_address_decoder #(.MASTERS(MASTERS)) uut (.clk, .arst_n, .bootMemorySelect,
    .remapSet, .remapClear, .sizeWrite, .instrSizeIn, .dataSizeIn, .req, .reqAddr, .ack,
    .err, .slaveSel, .extCs, .ramBlock, .localAddr, .remap, .bootRom, .instrSize,
    .dataSize, .ahbBlocks);
  task automatic cmp_ans(input logic [29:0] e, input logic [29:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR answer expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_count(input logic [15:0] g);
    checked++;
    if (g !== 16'h0)
    begin
      bad_count++;
      $display("ERROR pending expected 0 seen %0d", g);
    end
  endtask
  // state word: remap, boot rom, instruction size, data size, bus region block mask
  task automatic cmp_state(input logic [10:0] e);
    logic [10:0] g;
    #1;
    g = {remap, bootRom, instrSize, dataSize, ahbBlocks};
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR state expected %h seen %h", e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // k is 0 or 7; one master per cycle keeps answers in queue order
  // chip select index: ext0 banks 1-6 give 0-5, ext1 banks 7-9 give 0-2, boot ext gives 0
  task automatic acc(input int k, input logic [31:0] a, input int s, input logic [2:0] b);
    logic [3:0] cs;
    cs = (s == 3 && a[31:28] != 4'h0) ? a[31:28] - 4'h1 : (s == 4) ? a[31:28] - 4'h7 : 4'h0;
    @(posedge clk);
    go <= {k == 7, k == 0};
    if (k == 7)
      ga7 <= a;
    else
      ga0 <= a;
    q.push_back({s != 6, s == 6, 7'(1 << s), b, cs, a[13:0]});
  endtask
  task automatic drain(input logic [10:0] st);
    @(posedge clk);
    go <= 2'h0;
    repeat (4) @(posedge clk);
    cmp_count(16'(q.size()));
    cmp_state(st);
  endtask
  // w: 0 set remap, 1 clear remap, 2 load sizes, 3 set and clear together
  task automatic pulse(input int w, input logic [1:0] i, input logic [1:0] d,
                       input logic [10:0] st);
    @(posedge clk);
    remapSet <= w == 0 || w == 3;
    remapClear <= w == 1 || w == 3;
    sizeWrite <= w == 2;
    instrSizeIn <= i;
    dataSizeIn <= d;
    @(posedge clk);
    {remapSet, remapClear, sizeWrite} <= 3'h0;
    drain(st);
  endtask
  task automatic do_reset(input logic strap, input logic [10:0] st);
    @(posedge clk);
    arst_n <= 1'b0;
    bootMemorySelect <= strap;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    cmp_state(st);
  endtask
  always @(posedge clk)
  begin
    #1;
    for (int k = 0; k < MASTERS; k += 7)
      if (ack[k] === 1'b1 || err[k] === 1'b1)
      begin
        got = {ack[k], err[k], slaveSel[k*7+:7], slaveSel[k*7+1] ? ramBlock[k*3+:3] : 3'h0,
               extCs[k*4+:4], localAddr[k*14+:14]};
        cmp_ans(q.size() ? q.pop_front() : 30'h0, got);
      end
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    final_report;
  end
  initial
  begin
    int          s;
    logic [31:0] ad;
    void'($urandom(20));
    do_reset(1'b1, {1'b0, 1'b1, 2'h0, 2'h0, 5'h1f});
    acc(7, 32'h0, 0, 3'h0);
    acc(0, 32'h0, 0, 3'h0);
    for (int b = 1; b < 16; b++)
    begin
      s = b < 7 ? 3 : b < 10 ? 4 : b == 15 ? 5 : 6;
      acc(b % 2 * 7, {4'(b), 28'($urandom)}, s, 3'h0);
    end
    for (int k = 0; k < 5; k++)
    begin
      ad = 32'h0030_0000 + 32'(k * 16384) + 32'($urandom % 16384);
      acc(k % 2 * 7, ad, 1, 3'(4 - k));
    end
    acc(0, 32'h0010_0000, 6, 3'h0);
    acc(0, 32'h0040_0000, 0, 3'h0);
    acc(7, 32'h0050_0000, 2, 3'h0);
    drain({1'b0, 1'b1, 2'h0, 2'h0, 5'h1f});
    pulse(2, 2'h3, 2'h1, {1'b0, 1'b1, 2'h2, 2'h1, 5'h14});
    acc(0, 32'h0010_0000, 1, 3'h1);
    acc(0, 32'h0010_4000, 1, 3'h0);
    acc(0, 32'h0020_0000, 1, 3'h3);
    acc(7, 32'h0020_4000, 6, 3'h0);
    acc(7, 32'h0030_0000, 1, 3'h4);
    acc(7, 32'h0030_4000, 1, 3'h2);
    acc(0, 32'h0030_8000, 6, 3'h0);
    drain({1'b0, 1'b1, 2'h2, 2'h1, 5'h14});
    pulse(0, 2'h2, 2'h1, {1'b1, 1'b1, 2'h2, 2'h1, 5'h14});
    acc(7, 32'h0, 1, 3'h4);
    acc(0, 32'h0, 0, 3'h0);
    drain({1'b1, 1'b1, 2'h2, 2'h1, 5'h14});
    pulse(1, 2'h2, 2'h1, {1'b0, 1'b1, 2'h2, 2'h1, 5'h14});
    acc(7, 32'h0, 0, 3'h0);
    drain({1'b0, 1'b1, 2'h2, 2'h1, 5'h14});
    pulse(3, 2'h2, 2'h1, {1'b1, 1'b1, 2'h2, 2'h1, 5'h14});
    do_reset(1'b0, {1'b0, 1'b0, 2'h0, 2'h0, 5'h1f});
    acc(7, 32'h0, 3, 3'h0);
    acc(7, 32'h0030_4000, 1, 3'h3);
    drain({1'b0, 1'b0, 2'h0, 2'h0, 5'h1f});
    final_report;
  end
endmodule // sad_system_address_decoder_tb
bind sad_system_address_decoder sad_chk #(.MASTERS(MASTERS)) chk (.clk, .arst_n, .remapSet,
  .sizeWrite, .instrSizeIn, .req, .reqAddr, .ack, .err, .slaveSel, .ramBlock, .remap,
  .instrSize);
`default_nettype wire
